//--- include/rib_pkg.sv
// shared constants and types for the rtd parameter bank link
// assumes a 20 MHz system clock on both ends
`default_nettype none
package rib_pkg;
  localparam int NUM_CH = 4; // input channels
  localparam int NUM_PAR = 8; // parameter bytes
  // byte positions inside the parameter bank
  localparam logic [2:0] IDX_DIAG = 3'h0;
  localparam logic [2:0] IDX_WIRE = 3'h1;
  localparam logic [2:0] IDX_UNIT = 3'h2;
  localparam logic [2:0] IDX_MAINS_REJECT_SELECT = 3'h3;
  localparam logic [2:0] IDX_CH0 = 3'h4;
  // dictionary addressing on the link
  localparam logic [7:0] SUBIDX_FIRST = 8'h01;
  localparam logic [7:0] SUBIDX_LAST = 8'h08;
  localparam logic [15:0] DICT_BASE = 16'h3100;
  localparam logic [15:0] DICT_LAST = 16'h3107;
  // record set numbers
  localparam logic [7:0] REC_GLOBAL = 8'h00;
  localparam logic [7:0] REC_UNIT = 8'h01;
  localparam logic [7:0] REC_CH_FIRST = 8'h80;
  localparam logic [7:0] REC_CH_LAST = 8'h83;
  // reset values
  localparam logic [7:0] DIAG_RST = 8'h00;
  localparam logic [7:0] WIRE_RST = 8'h00;
  localparam logic [7:0] UNIT_RST = 8'h00;
  localparam logic [7:0] MAINS_REJECT_SELECT_RST = 8'h02;
  localparam logic [7:0] FN_RST = 8'h50;
  localparam logic [7:0] FN_OFF = 8'hFF;
  // field encodings and writable masks
  localparam logic [7:0] DIAG_ON = 8'h40;
  localparam logic [7:0] DIAG_OFF = 8'h00;
  localparam logic [7:0] WIRE_MASK = 8'h0F;
  localparam logic [7:0] UNIT_MASK = 8'h03;
  localparam logic [7:0] MAINS_REJECT_SELECT_MASK = 8'h03;
  localparam logic [1:0] UNIT_F = 2'b01;
  localparam logic [1:0] UNIT_K = 2'b10;
  localparam logic [1:0] MAINS_REJECT_SELECT_60 = 2'b01;
  // temperature functions report tenths of a degree celsius
  localparam logic [7:0] FN_TEMP_LO = 8'h50;
  localparam logic [7:0] FN_TEMP_HI = 8'h63;
  localparam int F_OFS = 320; // 32.0 degrees in tenths
  localparam int K_OFS = 2732; // 273.2 kelvin in tenths
  localparam logic [15:0] WIRE_BREAK_WORD = 16'h7FFF;
  // conversion timing
  localparam int CLK_MHZ = 20;
  localparam int CONV_50HZ_US = 84200;
  localparam int CONV_60HZ_US = 70500;
  localparam int CONV_50HZ_CYC = CONV_50HZ_US * CLK_MHZ;
  localparam int CONV_60HZ_CYC = CONV_60HZ_US * CLK_MHZ;
  // coupler register offsets and command fields
  localparam logic [7:0] WB_CTRL = 8'h00;
  localparam logic [7:0] WB_CMD = 8'h04;
  localparam logic [7:0] WB_STAT = 8'h08;
  localparam logic [7:0] WB_IN0 = 8'h10;
  localparam int IN_STEP = 2; // input area step per channel in 16-bit words
  localparam int CMD_BYTE_BIT = 16;
  localparam int CMD_DICT_BIT = 30;
  localparam int CMD_WR_BIT = 31;
  // scan sequencer states, gray along scan, conv, store
  typedef enum logic [1:0] {
    RIB_SCAN = 2'b00,
    RIB_CONV = 2'b01,
    RIB_STORE = 2'b11
  } rib_state_t;
endpackage : rib_pkg
`default_nettype wire

//--- include/rib_if.sv
// link between the coupler and the input module
// assumes both ends share one clock
`timescale 1ns/1ps
`default_nettype none
interface rib_if;
  logic par_req; // parameter access held until ack
  logic par_we; // write when high
  logic [7:0] par_subidx; // dictionary subindex 01h..08h
  logic [7:0] par_wdata; // byte to write
  logic par_ack; // one-cycle answer
  logic [7:0] par_rdata; // byte read back
  logic par_err; // subindex out of range
  logic sys_run; // high in run, low in stop
  logic [3:0][15:0] in_word; // input area words
  logic diag_irq; // diagnostic interrupt level
  modport dev (input par_req, par_we, par_subidx, par_wdata, sys_run,
    output par_ack, par_rdata, par_err, in_word, diag_irq);
  modport coupler (output par_req, par_we, par_subidx, par_wdata, sys_run,
    input par_ack, par_rdata, par_err, in_word, diag_irq);
endinterface : rib_if
`default_nettype wire

//--- rtl/rib_dev.sv
// input module end: parameter bank, channel scan, input words, leds
// assumes a front end on the same clock answering FE_VALUE per channel
// Overview of operation
// - scan active channels; 84.2/70.5 ms each
// - diag byte 00h off, 40h interrupts on
// - wire-break bits 0..3 enable channel detection
// - unit bits: 00 C, 01 F, 10 K
// - suppression 01 60 Hz, 10 50 Hz; 02h
// - per-channel range byte; FFh deactivates channel
// - range defaults 50h, suppression 02h, other bytes 00h
// - two-channel build: channels 2, 3 default FFh
// - global record written only in stop
// - records 00h, 01h, 80h..83h group bytes
// - bytes at 3100h.. or subindex 01h..08h
// - module state, module error, channel error leds
// - one input word per channel, +0..+6
// - partner and unused channels must be off
`timescale 1ns/1ps
`default_nettype none
module rib_dev
  import rib_pkg::*;
#(
  parameter bit TWO_CHANNEL = 1'b0, // two-channel build
  parameter int CONV_50_CYC = CONV_50HZ_CYC, // cycles per 50 Hz conversion
  parameter int CONV_60_CYC = CONV_60HZ_CYC // cycles per 60 Hz conversion
) (
  input wire logic CLK, // system clock
  input wire logic RESETN, // async reset, active low
  rib_if.dev LINK, // coupler link
  output logic [1:0] FE_CHANNEL, // channel under conversion
  output logic [7:0] FE_RANGE, // its range code
  output logic FE_SAMPLE, // result taken this cycle
  input wire logic [15:0] FE_VALUE, // front end result
  input wire logic FE_OPEN, // front end sees open circuit
  output logic MOD_OK_LED, // module state
  output logic MOD_ERR_LED, // module error
  output logic [3:0] CH_ERR_LED // per channel error
);

  // reset value of one bank byte
  function automatic logic [7:0] rst_val(input int i);
    logic [7:0] v;
    v = FN_RST;
    if (i == int'(IDX_DIAG)) v = DIAG_RST;
    if (i == int'(IDX_WIRE)) v = WIRE_RST;
    if (i == int'(IDX_UNIT)) v = UNIT_RST;
    if (i == int'(IDX_MAINS_REJECT_SELECT)) v = MAINS_REJECT_SELECT_RST;
    if (TWO_CHANNEL && i >= int'(IDX_CH0) + 2) v = FN_OFF;
    return v;
  endfunction : rst_val

  // writable bits of one bank byte
  function automatic logic [7:0] wr_mask(input logic [2:0] i);
    logic [7:0] m;
    m = 8'hFF;
    if (i == IDX_WIRE) m = WIRE_MASK;
    if (i == IDX_UNIT) m = UNIT_MASK;
    if (i == IDX_MAINS_REJECT_SELECT) m = MAINS_REJECT_SELECT_MASK;
    return m;
  endfunction : wr_mask

  logic [7:0] bank_reg [NUM_PAR]; // parameter bytes
  logic ack_reg; // link answer
  logic [7:0] rdata_reg; // link read data
  logic err_reg; // link address error
  rib_state_t state_reg; // scan state
  rib_state_t state_next;
  logic [1:0] ch_reg; // current channel
  logic [31:0] timer_reg; // conversion countdown
  logic [3:0][15:0] word_reg; // input words
  logic [3:0] cherr_reg; // channel errors
  logic sample_reg; // front end sample strobe
  logic ok_reg; // module state led
  logic merr_reg; // module error led
  logic irq_reg; // diagnostic interrupt
  logic [7:0] range_reg; // range code shown to the front end

  // named views of the bank
  wire [7:0] diag_irq_enable = bank_reg[IDX_DIAG];
  wire [7:0] open_wire_detect_enable = bank_reg[IDX_WIRE];
  wire [7:0] temperature_unit_select = bank_reg[IDX_UNIT];
  wire [7:0] mains_reject_select = bank_reg[IDX_MAINS_REJECT_SELECT];
  wire [7:0] channel_range_code = bank_reg[IDX_CH0 + 3'(ch_reg)];

  // link decode: subindex 01h..08h maps to bank bytes
  wire link_hit = LINK.par_req && !ack_reg;
  wire sub_ok = LINK.par_subidx >= SUBIDX_FIRST && LINK.par_subidx <= SUBIDX_LAST;
  wire [7:0] sub_ofs = LINK.par_subidx - SUBIDX_FIRST;
  wire [2:0] par_idx = sub_ofs[2:0];
  wire par_wr = link_hit && sub_ok && LINK.par_we;

  // scan decode
  wire ch_active = channel_range_code != FN_OFF;
  wire any_active = bank_reg[4] != FN_OFF || bank_reg[5] != FN_OFF
    || bank_reg[6] != FN_OFF || bank_reg[7] != FN_OFF;
  wire [31:0] conv_load = (mains_reject_select[1:0] == MAINS_REJECT_SELECT_60) ?
    32'(CONV_60_CYC) : 32'(CONV_50_CYC);
  wire conv_end = timer_reg <= 32'h00000001;
  wire is_temp = channel_range_code >= FN_TEMP_LO && channel_range_code <= FN_TEMP_HI;
  wire wire_break = FE_OPEN && open_wire_detect_enable[ch_reg];

  // unit conversion of tenths of celsius
  wire signed [31:0] raw_s = 32'(signed'(FE_VALUE));
  wire signed [31:0] fahr_s = (raw_s * 9) / 5 + F_OFS;
  wire signed [31:0] kelv_s = raw_s + K_OFS;
  wire [1:0] unit_sel = temperature_unit_select[1:0];
  wire [15:0] temp_word = (unit_sel == UNIT_F) ? fahr_s[15:0] :
    (unit_sel == UNIT_K) ? kelv_s[15:0] : FE_VALUE;
  wire [15:0] value_word = wire_break ? WIRE_BREAK_WORD :
    is_temp ? temp_word : FE_VALUE;

  // bank writes from the link, reserved bits dropped
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      for (int i = 0; i < NUM_PAR; i++)
      begin
        bank_reg[i] <= rst_val(i);
      end
    end
    else if (par_wr)
    begin
      bank_reg[par_idx] <= LINK.par_wdata & wr_mask(par_idx);
    end
  end

  // link answer one cycle after the request is seen
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 8'h00;
      err_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= link_hit;
      if (link_hit)
      begin
        rdata_reg <= sub_ok ? bank_reg[par_idx] : 8'h00;
        err_reg <= !sub_ok;
      end
    end
  end

  // scan state transitions
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      RIB_SCAN:
        if (ch_active) state_next = RIB_CONV;
      RIB_CONV:
        if (conv_end) state_next = RIB_STORE;
      RIB_STORE:
        state_next = RIB_SCAN;
      default:
        state_next = RIB_SCAN;
    endcase
  end

  // state, channel pointer and conversion timer
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_reg <= RIB_SCAN;
      ch_reg <= 2'h0;
      timer_reg <= 32'h00000000;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == RIB_SCAN && ch_active)
      begin
        timer_reg <= conv_load;
      end
      else if (state_reg == RIB_CONV)
      begin
        timer_reg <= timer_reg - 32'h00000001;
      end
      // channels are converted one after another
      if ((state_reg == RIB_SCAN && !ch_active) || state_reg == RIB_STORE)
      begin
        ch_reg <= ch_reg + 2'h1;
      end
    end
  end

  // input words and channel errors
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      word_reg <= '0;
      cherr_reg <= 4'h0;
    end
    else if (state_reg == RIB_SCAN && !ch_active)
    begin
      word_reg[ch_reg] <= 16'h0000;
      cherr_reg[ch_reg] <= 1'b0;
    end
    else if (state_reg == RIB_STORE)
    begin
      word_reg[ch_reg] <= value_word;
      cherr_reg[ch_reg] <= wire_break;
    end
  end

  // indicators and diagnostic interrupt
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      sample_reg <= 1'b0;
      ok_reg <= 1'b0;
      merr_reg <= 1'b0;
      irq_reg <= 1'b0;
      range_reg <= FN_RST;
    end
    else
    begin
      sample_reg <= state_next == RIB_STORE;
      // one cycle behind the pointer, settled before conversion starts
      range_reg <= channel_range_code;
      ok_reg <= any_active;
      merr_reg <= |cherr_reg;
      irq_reg <= diag_irq_enable == DIAG_ON && |cherr_reg;
    end
  end

  // link outputs
  assign LINK.par_ack = ack_reg;
  assign LINK.par_rdata = rdata_reg;
  assign LINK.par_err = err_reg;
  assign LINK.in_word = word_reg;
  assign LINK.diag_irq = irq_reg;

  // user side outputs
  assign FE_CHANNEL = ch_reg;
  assign FE_RANGE = range_reg;
  assign FE_SAMPLE = sample_reg;
  assign MOD_OK_LED = ok_reg;
  assign MOD_ERR_LED = merr_reg;
  assign CH_ERR_LED = cherr_reg;

endmodule : rib_dev
`default_nettype wire

//--- rtl/rib_coupler.sv
// coupler end: wishbone registers drive parameter accesses on the link
// assumes a classic wishbone master on the same clock
`timescale 1ns/1ps
`default_nettype none
module rib_coupler
  import rib_pkg::*;
(
  input wire logic CLK, // system clock
  input wire logic RESETN, // async reset, active low
  rib_if.coupler LINK, // module link
  input wire logic WB_CYC_I, // bus cycle
  input wire logic WB_STB_I, // strobe
  input wire logic WB_WE_I, // write enable
  input wire logic [7:0] WB_ADR_I, // byte address
  input wire logic [3:0] WB_SEL_I, // byte lanes
  input wire logic [31:0] WB_DAT_I, // write data
  output logic [31:0] WB_DAT_O, // read data
  output logic WB_ACK_O // acknowledge
);

  logic ack_reg; // bus answer
  logic [31:0] dat_reg; // bus read data
  logic run_reg; // run when high
  logic req_reg; // link access pending
  logic we_reg; // pending access writes
  logic [7:0] sub_reg; // pending subindex
  logic [7:0] wd_reg; // pending write byte
  logic [7:0] rd_reg; // last byte read
  logic refused_reg; // refused in run
  logic bad_reg; // address not mapped

  // bus decode
  wire bus_go = WB_CYC_I && WB_STB_I && !ack_reg;
  wire wr_ok = bus_go && WB_WE_I && (&WB_SEL_I);
  wire ctrl_wr = wr_ok && WB_ADR_I == WB_CTRL;
  wire cmd_wr = wr_ok && WB_ADR_I == WB_CMD && !req_reg;

  // record set or dictionary index to subindex
  wire [7:0] rec = WB_DAT_I[15:8];
  wire byte_sel = WB_DAT_I[CMD_BYTE_BIT];
  wire [15:0] dict = WB_DAT_I[23:8];
  wire [15:0] dict_ofs = dict - DICT_BASE;
  wire [7:0] rec_ofs = rec - REC_CH_FIRST;
  wire use_dict = WB_DAT_I[CMD_DICT_BIT];
  wire dict_ok = dict >= DICT_BASE && dict <= DICT_LAST;
  wire rec_ok = rec == REC_GLOBAL || rec == REC_UNIT
    || (rec >= REC_CH_FIRST && rec <= REC_CH_LAST && !byte_sel);
  wire [7:0] rec_sub = (rec == REC_GLOBAL) ? 8'(byte_sel) + 8'h01 :
    (rec == REC_UNIT) ? 8'(byte_sel) + 8'h03 : rec_ofs + 8'h05;
  wire [7:0] cmd_sub = use_dict ? dict_ofs[7:0] + SUBIDX_FIRST : rec_sub;
  wire cmd_ok = use_dict ? dict_ok : rec_ok;
  wire is_global = cmd_sub <= 8'h02;
  wire cmd_write = WB_DAT_I[CMD_WR_BIT];
  wire cmd_refuse = cmd_write && is_global && run_reg;
  wire cmd_start = cmd_wr && cmd_ok && !cmd_refuse;

  // read selection
  wire [7:0] in_ofs = WB_ADR_I - WB_IN0;
  wire in_hit = WB_ADR_I >= WB_IN0 && in_ofs < 8'(4 * NUM_CH) && in_ofs[1:0] == 2'h0;
  wire [31:0] stat_word = {16'h0000, rd_reg, 3'h0, LINK.diag_irq,
    1'b0, bad_reg, refused_reg, req_reg};
  wire [31:0] rd_mux = (WB_ADR_I == WB_CTRL) ? {31'h0, run_reg} :
    (WB_ADR_I == WB_STAT) ? stat_word :
    in_hit ? {16'h0000, LINK.in_word[in_ofs[3:2]]} : 32'h00000000;

  // bus answer one cycle after the strobe
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end
    else
    begin
      ack_reg <= bus_go;
      if (bus_go) dat_reg <= rd_mux;
    end
  end

  // run control and link access
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      run_reg <= 1'b0;
      req_reg <= 1'b0;
      we_reg <= 1'b0;
      sub_reg <= 8'h00;
      wd_reg <= 8'h00;
      rd_reg <= 8'h00;
      refused_reg <= 1'b0;
      bad_reg <= 1'b0;
    end
    else
    begin
      if (ctrl_wr) run_reg <= WB_DAT_I[0];
      if (cmd_wr)
      begin
        refused_reg <= cmd_refuse;
        bad_reg <= !cmd_ok;
      end
      if (cmd_start)
      begin
        req_reg <= 1'b1;
        we_reg <= cmd_write;
        sub_reg <= cmd_sub;
        wd_reg <= WB_DAT_I[7:0];
      end
      else if (req_reg && LINK.par_ack)
      begin
        req_reg <= 1'b0;
        rd_reg <= LINK.par_rdata;
        bad_reg <= LINK.par_err;
      end
    end
  end

  assign LINK.par_req = req_reg;
  assign LINK.par_we = we_reg;
  assign LINK.par_subidx = sub_reg;
  assign LINK.par_wdata = wd_reg;
  assign LINK.sys_run = run_reg;
  assign WB_DAT_O = dat_reg;
  assign WB_ACK_O = ack_reg;

endmodule : rib_coupler
`default_nettype wire

//--- sim/rib_checker.sv
// assertions on the parameter link between coupler and input module
// assumes instantiation beside the link interface, one clock, async low reset
`timescale 1ns/1ps
`default_nettype none
module rib_checker
  import rib_pkg::*;
(
  input wire logic CLK, // system clock
  input wire logic RESETN, // async reset, active low
  input wire logic par_req, // access pending
  input wire logic par_we, // write access
  input wire logic [7:0] par_subidx, // subindex
  input wire logic [7:0] par_wdata, // write byte
  input wire logic par_ack, // answer pulse
  input wire logic [7:0] par_rdata, // read byte
  input wire logic par_err, // bad subindex
  input wire logic sys_run, // run or stop
  input wire logic [3:0][15:0] in_word, // input words
  input wire logic diag_irq // diagnostic level
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  // subindex outside the parameter bank
  wire bad_sub = (par_subidx < SUBIDX_FIRST) || (par_subidx > SUBIDX_LAST);
  // global byte touched by a write
  wire glob_wr = par_we && (par_subidx == 8'h01 || par_subidx == 8'h02);
  // access taken by the module
  sequence s_taken;
    par_req && !par_ack;
  endsequence
  // diagnostic byte cleared in stop
  sequence s_diag_off;
    par_ack && par_we && !par_err && par_subidx == SUBIDX_FIRST && par_wdata == DIAG_OFF;
  endsequence
  chk_ack_next: assert property (s_taken |=> par_ack)
    else $error("link access not answered one cycle later");
  chk_ack_pulse: assert property (par_ack |=> !par_ack)
    else $error("link answer longer than one cycle");
  chk_req_release: assert property (par_req && par_ack |=> !par_req)
    else $error("link request held after answer");
  chk_err_range: assert property (par_ack |-> par_err == bad_sub)
    else $error("subindex error flag wrong");
  chk_bad_zero: assert property (par_ack && par_err |-> par_rdata == 8'h00)
    else $error("bad subindex returned data");
  chk_rdata_hold: assert property (!par_ack |-> $stable(par_rdata))
    else $error("read byte changed without answer");
  chk_global_stop: assert property (par_req && glob_wr |-> !sys_run)
    else $error("global byte written in run");
  chk_diag_quiet: assert property (s_diag_off |-> ##2 !diag_irq)
    else $error("diagnostic level with interrupts off");
  chk_wire_rsvd: assert property (par_ack && !par_we && par_subidx == 8'h02
    |-> par_rdata[7:4] == 4'h0)
    else $error("wire break reserved bits not zero");
  chk_unit_rsvd: assert property (par_ack && !par_we && (par_subidx == 8'h03
    || par_subidx == 8'h04) |-> par_rdata[7:2] == 6'h00)
    else $error("unit or suppression reserved bits not zero");
endmodule : rib_checker
`default_nettype wire

//--- sim/tb_top.sv
// self-checking bench: coupler and input module joined by the link
// assumes shortened conversion counts and a bench-driven front end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rib_pkg::*;
  localparam int C50 = 20; // shortened 50 Hz conversion
  localparam int C60 = 16; // shortened 60 Hz conversion
  logic clk = 1'b0; // system clock
  logic resetn = 1'b0; // reset, active low
  logic cyc = 1'b0; // bus cycle
  logic stb = 1'b0; // bus strobe
  logic we = 1'b0; // bus write
  logic [7:0] adr = 8'h00; // bus address
  logic [31:0] wdat = 32'h0; // bus write data
  logic [31:0] q; // last read word
  logic [15:0] fe_val = 16'h0000; // front end result
  logic fe_open = 1'b0; // front end open circuit
  logic [15:0] fe_tab [4] = '{16'h0064, 16'h1234, 16'h0000, 16'h0000}; // channel values
  logic [3:0] open_tab = 4'b1000; // open channels
  wire [31:0] dat_o; // bus read data
  wire ack; // bus answer
  wire [1:0] fe_ch; // channel in conversion
  wire [7:0] fe_rng; // range code in conversion
  logic req2 = 1'b0; // second module link request
  logic [7:0] sub2 = 8'h00; // second module link subindex
  wire fe_smp; // sample strobe
  wire ok_led; // module state
  wire err_led; // module error
  wire [3:0] ch_led; // channel errors
  int num_errors = 0; // mismatches
  int n_tests = 0; // comparisons
  int cycles = 0; // timeout count
  rib_if link_if ();
  rib_dev #(.CONV_50_CYC(C50), .CONV_60_CYC(C60)) rib_dev_i (.CLK(clk), .RESETN(resetn),
    .LINK(link_if.dev), .FE_CHANNEL(fe_ch), .FE_RANGE(fe_rng), .FE_SAMPLE(fe_smp),
    .FE_VALUE(fe_val), .FE_OPEN(fe_open), .MOD_OK_LED(ok_led), .MOD_ERR_LED(err_led),
    .CH_ERR_LED(ch_led));
  rib_coupler rib_coupler_i (.CLK(clk), .RESETN(resetn), .LINK(link_if.coupler),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
    .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack));
  rib_checker rib_checker_i (.CLK(clk), .RESETN(resetn), .par_req(link_if.par_req),
    .par_we(link_if.par_we), .par_subidx(link_if.par_subidx),
    .par_wdata(link_if.par_wdata), .par_ack(link_if.par_ack),
    .par_rdata(link_if.par_rdata), .par_err(link_if.par_err),
    .sys_run(link_if.sys_run), .in_word(link_if.in_word), .diag_irq(link_if.diag_irq));
  // second module in two-channel build, read straight over its own link
  rib_if link2_if ();
  assign link2_if.par_req = req2;
  assign link2_if.par_we = 1'b0;
  assign link2_if.par_subidx = sub2;
  assign link2_if.par_wdata = 8'h00;
  assign link2_if.sys_run = 1'b0;
  rib_dev #(.TWO_CHANNEL(1'b1), .CONV_50_CYC(C50), .CONV_60_CYC(C60))
    rib_dev_two_i (.CLK(clk), .RESETN(resetn), .LINK(link2_if.dev), .FE_CHANNEL(),
    .FE_RANGE(), .FE_SAMPLE(), .FE_VALUE(16'h0000), .FE_OPEN(1'b0), .MOD_OK_LED(),
    .MOD_ERR_LED(), .CH_ERR_LED());
  // clock
  always #25 clk = ~clk;
  // front end answers per channel
  always @(posedge clk)
  begin
    fe_val <= fe_tab[fe_ch];
    fe_open <= open_tab[fe_ch];
  end
  // hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    if (num_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // one classic bus cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  // command, then poll status until idle
  task automatic par(input logic [31:0] cmd);
    wb(1'b1, WB_CMD, cmd);
    do wb(1'b0, WB_STAT, 32'h0); while (q[0] !== 1'b0);
  endtask : par
  // dictionary access to one byte
  task automatic dict(input logic w, input logic [7:0] sub, input logic [7:0] d);
    par({w, 1'b1, 6'h00, DICT_BASE + {8'h00, sub} - 16'h0001, d});
  endtask : dict
  // record access, sec picks the second byte
  task automatic rec(input logic [7:0] r, input logic sec, input logic [7:0] d);
    par({1'b1, 1'b0, 6'h00, 7'h00, sec, r, d});
  endtask : rec
  task automatic t_defaults;
    logic [7:0] dft [8] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h50, 8'h50, 8'h50, 8'h50};
    for (int i = 0; i < 8; i++)
    begin
      dict(1'b0, 8'(i + 1), 8'h00);
      check(q[15:8], dft[i]);
    end
  endtask : t_defaults
  task automatic t_reserved;
    for (int s = 2; s < 5; s++)
    begin
      dict(1'b1, 8'(s), 8'hFF);
      dict(1'b0, 8'(s), 8'h00);
      check(q[15:8], (s == 2) ? 8'h0F : 8'h03);
    end
    rec(REC_UNIT, 1'b0, 8'h00);
    rec(REC_UNIT, 1'b1, 8'h02);
    dict(1'b0, 8'h04, 8'h00);
    check(q[15:8], 8'h02);
  endtask : t_reserved
  task automatic t_config;
    logic [7:0] code [4] = '{8'h50, 8'h70, 8'hFF, 8'h50};
    for (int k = 0; k < 4; k++)
    begin
      rec(REC_CH_FIRST + 8'(k), 1'b0, code[k]);
      dict(1'b0, 8'(k + 5), 8'h00);
      check(q[15:8], code[k]);
    end
  endtask : t_config
  task automatic t_run;
    wb(1'b1, WB_CTRL, 32'h1);
    dict(1'b1, 8'h01, DIAG_ON);
    check(q[1], 1'b1);
    wb(1'b1, WB_CTRL, 32'h0);
    dict(1'b0, 8'h01, 8'h00);
    check(q[15:8], 8'h00);
    dict(1'b0, 8'h09, 8'h00);
    check(q[2], 1'b1);
    wb(1'b0, 8'h20, 32'h0);
    check(q, 32'h0);
  endtask : t_run
  task automatic t_scan;
    logic [15:0] exp_w [4] = '{16'h0064, 16'h1234, 16'h0000, WIRE_BREAK_WORD};
    logic [15:0] exp_u [2] = '{16'h01F4, 16'h0B10};
    dict(1'b1, 8'h02, 8'h08);
    repeat (150) @(posedge clk);
    for (int k = 0; k < 4; k++)
    begin
      wb(1'b0, WB_IN0 + 8'(4 * k), 32'h0);
      check(q[15:0], exp_w[k]);
    end
    check({ch_led, err_led, ok_led}, 6'b100011);
    dict(1'b1, 8'h01, DIAG_ON);
    check(q[4], 1'b1);
    dict(1'b1, 8'h01, DIAG_OFF);
    check(q[4], 1'b0);
    for (int u = 0; u < 2; u++)
    begin
      dict(1'b1, 8'h03, 8'(u + 1));
      repeat (150) @(posedge clk);
      wb(1'b0, WB_IN0, 32'h0);
      check(q[15:0], exp_u[u]);
    end
  endtask : t_scan
  task automatic t_timing;
    int n;
    for (int s = 1; s < 3; s++)
    begin
      dict(1'b1, 8'h04, 8'(s));
      do @(posedge clk); while (!(fe_smp === 1'b1 && fe_ch === 2'd0));
      check(fe_rng, 8'h50);
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end while (!(fe_smp === 1'b1 && fe_ch === 2'd1));
      check(n, (s == 1) ? C60 + 2 : C50 + 2);
    end
  endtask : t_timing
  // two-channel build: channels 2 and 3 come up off, bad subindex flagged
  task automatic t_two_ch;
    logic [8:0] exp2 [3] = '{{1'b0, FN_OFF}, {1'b0, FN_OFF}, 9'h100};
    for (int s = 7; s < 10; s++)
    begin
      req2 <= 1'b1;
      sub2 <= 8'(s);
      do @(posedge clk); while (link2_if.par_ack !== 1'b1);
      check({link2_if.par_err, link2_if.par_rdata}, exp2[s - 7]);
      req2 <= 1'b0;
      @(posedge clk);
    end
  endtask : t_two_ch
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_defaults();
    t_reserved();
    t_config();
    t_run();
    t_scan();
    t_timing();
    t_two_ch();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
